// ---- rtl/sfifo_top.sv ----
`timescale 1ns/1ns
module sfifo_top
#(
  parameter int BITS_PER_SYMBOL = 8,
  parameter int SYMBOLS_PER_BEAT = 1,
  parameter int ERROR_W = 0,
  parameter int DEPTH = 16,
  parameter bit USE_PACKETS = 1'b1,
  parameter bit USE_CHANNEL = 1'b0,
  parameter int CHANNEL_W = 1,
  parameter bit USE_MAX_CHANNEL = 1'b0,
  parameter int MAX_CHANNEL = 255,
  parameter bit USE_STORE_FWD = 1'b0,
  parameter bit USE_FILL_LEVEL = 1'b1,
  parameter bit USE_ALMOST_FULL = 1'b1,
  parameter bit USE_ALMOST_EMPTY = 1'b1,
  parameter bit DUAL_CLOCK = 1'b0,
  parameter bit USE_SINK_FILL = 1'b1,
  parameter bit USE_SOURCE_FILL = 1'b1,
  parameter int WR_SYNC_LEN = 2,
  parameter int RD_SYNC_LEN = 2
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [BITS_PER_SYMBOL*SYMBOLS_PER_BEAT-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [((ERROR_W > 0) ? ERROR_W : 1)-1:0] in_error,
  input wire logic [CHANNEL_W-1:0] in_channel,
  output logic [BITS_PER_SYMBOL*SYMBOLS_PER_BEAT-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic out_sop,
  output logic out_eop,
  output logic [((ERROR_W > 0) ? ERROR_W : 1)-1:0] out_error,
  output logic [CHANNEL_W-1:0] out_channel,
  output logic almost_full,
  output logic almost_empty,
  input wire sfifo_pkg::sfifo_mm_req_t csr_in_req,
  output logic [sfifo_pkg::REG_W-1:0] csr_in_readdata,
  output logic csr_in_waitrequest,
  input wire sfifo_pkg::sfifo_mm_req_t csr_out_req,
  output logic [sfifo_pkg::REG_W-1:0] csr_out_readdata,
  output logic csr_out_waitrequest
);
  localparam int DW = BITS_PER_SYMBOL * SYMBOLS_PER_BEAT; // [R18]
  localparam int EW = (ERROR_W > 0) ? ERROR_W : 1; // [R20]
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int E_EOP = DW;
  localparam int E_SOP = DW + 1;
  localparam int E_ERR = DW + 2;
  localparam int E_CH = DW + 2 + EW;
  localparam int ENT_W = E_CH + CHANNEL_W;
  localparam bit SF_BUILD = USE_STORE_FWD && !DUAL_CLOCK; // [R12]
  localparam logic [sfifo_pkg::CNT_W-1:0] DEPTH_C = sfifo_pkg::CNT_W'(DEPTH);
  localparam logic [sfifo_pkg::LVL_W-1:0] ALMOST_FULL_RST = sfifo_pkg::LVL_W'(DEPTH - 1);

  if (BITS_PER_SYMBOL < 1 || BITS_PER_SYMBOL > 32 || SYMBOLS_PER_BEAT < 1
      || SYMBOLS_PER_BEAT > 32 || ERROR_W < 0 || ERROR_W > 32 || DEPTH < 1
      || DEPTH > sfifo_pkg::MAX_DEPTH || CHANNEL_W < 1 || CHANNEL_W > 32
      || MAX_CHANNEL < 1 || MAX_CHANNEL > 255)
  begin : g_bad_shape
    $error("sfifo_top: width, depth or channel parameter out of range");
  end
  if (DUAL_CLOCK && ((DEPTH & (DEPTH - 1)) != 0 || DEPTH < 2
      || WR_SYNC_LEN < sfifo_pkg::MIN_SYNC || WR_SYNC_LEN > sfifo_pkg::MAX_SYNC
      || RD_SYNC_LEN < sfifo_pkg::MIN_SYNC || RD_SYNC_LEN > sfifo_pkg::MAX_SYNC))
  begin : g_bad_dual
    $error("sfifo_top: dual form needs power-of-two depth and sync length 2 to 8");
  end

  logic [ENT_W-1:0] mem [DEPTH];
  logic [ENT_W-1:0] out_ent_r;
  logic [ENT_W-1:0] out_ent_nxt;
  logic out_valid_r;
  logic out_valid_nxt;
  sfifo_pkg::sfifo_fwd_t fwd_r;
  sfifo_pkg::sfifo_fwd_t fwd_nxt;
  logic [sfifo_pkg::LVL_W-1:0] af_thr_r;
  logic [sfifo_pkg::LVL_W-1:0] af_thr_nxt;
  logic [sfifo_pkg::LVL_W-1:0] ae_thr_r;
  logic [sfifo_pkg::LVL_W-1:0] ae_thr_nxt;
  logic [sfifo_pkg::LVL_W-1:0] cut_thr_r;
  logic [sfifo_pkg::LVL_W-1:0] cut_thr_nxt;
  logic drop_r;
  logic drop_nxt;
  logic almost_full_r;
  logic almost_empty_r;
  logic [1:0] ack_r;
  logic [1:0] ack_nxt;
  logic [sfifo_pkg::REG_W-1:0] rdata_r [2];
  logic [sfifo_pkg::REG_W-1:0] rdata_nxt [2];

  logic push;
  logic keep;
  logic eop_in;
  logic err_in;
  logic sf_mode;
  logic load_out;
  logic can_pop;
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [sfifo_pkg::CNT_W-1:0] fill_in;
  logic [sfifo_pkg::CNT_W-1:0] fill_out;
  logic [ENT_W-1:0] in_ent;

  // a threshold of zero only means store-and-forward when that build exists
  assign sf_mode = SF_BUILD && (cut_thr_r == '0); // [R09]
  assign push = in_valid && in_ready; // [R01] [R02]
  assign eop_in = USE_PACKETS ? in_eop : 1'b1; // [R22]
  assign err_in = (ERROR_W > 0) && (|in_error); // [R20]
  // beats on a channel above the maximum are taken and thrown away
  assign keep = push && !(USE_CHANNEL && USE_MAX_CHANNEL
                && (32'(in_channel) > 32'(MAX_CHANNEL))); // [R03]
  assign in_ent = {(USE_CHANNEL ? in_channel : CHANNEL_W'(0)),
                   ((ERROR_W > 0) ? in_error : EW'(0)),
                   (USE_PACKETS && in_sop), eop_in, in_data};
  assign load_out = can_pop && (!out_valid_r || out_ready); // [R06]

  always_ff @(posedge clk_sys)
  begin
    if (keep)
    begin
      mem[wr_idx] <= in_ent;
    end
  end

  if (DUAL_CLOCK) begin : g_dual
    // one clock serves both sides in this build; the crossing is kept whole
    // so the two sides may be split onto separate clocks without rework
    logic [AW:0] wr_bin_r;
    logic [AW:0] rd_bin_r;
    logic [AW:0] wr_gray_r;
    logic [AW:0] rd_gray_r;
    logic [AW:0] wr_sync_r [WR_SYNC_LEN];
    logic [AW:0] rd_sync_r [RD_SYNC_LEN];
    logic [AW:0] wr_seen;
    logic [AW:0] rd_seen;

    function automatic logic [AW:0] gray_to_bin(input logic [AW:0] g);
      logic [AW:0] b;
      b[AW] = g[AW];
      for (int i = AW - 1; i >= 0; i--)
      begin
        b[i] = b[i+1] ^ g[i];
      end
      return b;
    endfunction

    always_ff @(posedge clk_sys)
    begin
      if (srst)
      begin
        wr_bin_r <= '0;
        rd_bin_r <= '0;
        wr_gray_r <= '0;
        rd_gray_r <= '0;
        for (int i = 0; i < WR_SYNC_LEN; i++)
        begin
          wr_sync_r[i] <= '0;
        end
        for (int i = 0; i < RD_SYNC_LEN; i++)
        begin
          rd_sync_r[i] <= '0;
        end
      end
      else
      begin
        wr_bin_r <= wr_bin_r + (AW+1)'(keep);
        rd_bin_r <= rd_bin_r + (AW+1)'(load_out);
        wr_gray_r <= (wr_bin_r + (AW+1)'(keep)) ^ ((wr_bin_r + (AW+1)'(keep)) >> 1); // [R23]
        rd_gray_r <= (rd_bin_r + (AW+1)'(load_out))
                     ^ ((rd_bin_r + (AW+1)'(load_out)) >> 1); // [R23]
        wr_sync_r[0] <= wr_gray_r; // [R21]
        rd_sync_r[0] <= rd_gray_r; // [R21]
        for (int i = 1; i < WR_SYNC_LEN; i++)
        begin
          wr_sync_r[i] <= wr_sync_r[i-1];
        end
        for (int i = 1; i < RD_SYNC_LEN; i++)
        begin
          rd_sync_r[i] <= rd_sync_r[i-1];
        end
      end
    end

    assign wr_seen = gray_to_bin(wr_sync_r[WR_SYNC_LEN-1]);
    assign rd_seen = gray_to_bin(rd_sync_r[RD_SYNC_LEN-1]);
    // stale read pointer overstates input fill; stale write pointer understates output
    assign fill_in = sfifo_pkg::CNT_W'(wr_bin_r - rd_seen); // [R13]
    assign fill_out = sfifo_pkg::CNT_W'(wr_seen - rd_bin_r)
                      + sfifo_pkg::CNT_W'(out_valid_r); // [R13] [R14]
    assign in_ready = fill_in < DEPTH_C; // [R14]
    assign can_pop = wr_seen != rd_bin_r; // [R06]
    assign wr_idx = wr_bin_r[AW-1:0];
    assign rd_idx = rd_bin_r[AW-1:0];
  end
  else begin : g_single
    logic [AW-1:0] wr_idx_r;
    logic [AW-1:0] wr_idx_nxt;
    logic [AW-1:0] cwr_idx_r;
    logic [AW-1:0] cwr_idx_nxt;
    logic [AW-1:0] rd_idx_r;
    logic [AW-1:0] rd_idx_nxt;
    logic [sfifo_pkg::CNT_W-1:0] com_r;
    logic [sfifo_pkg::CNT_W-1:0] com_nxt;
    logic [sfifo_pkg::CNT_W-1:0] unc_r;
    logic [sfifo_pkg::CNT_W-1:0] unc_nxt;
    logic bad_r;
    logic bad_nxt;
    logic [sfifo_pkg::CNT_W-1:0] occ;
    logic [sfifo_pkg::LVL_W-1:0] thresh;
    logic gate;

    function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] v);
      return (32'(v) == DEPTH - 1) ? '0 : v + AW'(1);
    endfunction

    assign occ = com_r + unc_r + sfifo_pkg::CNT_W'(out_valid_r); // [R19]
    assign thresh = SF_BUILD ? cut_thr_r : sfifo_pkg::LVL_W'(1); // [R11] [R12]
    // a started packet keeps flowing even if the fill drops below threshold
    assign gate = sf_mode || (fwd_r == sfifo_pkg::SFIFO_FWD_PKT)
                  || (sfifo_pkg::LVL_W'(occ) >= thresh); // [R10] [R12]
    assign can_pop = (com_r != '0) && gate; // [R07]
    assign in_ready = (com_r + unc_r) < DEPTH_C;
    assign fill_in = occ;
    assign fill_out = occ;
    assign wr_idx = wr_idx_r;
    assign rd_idx = rd_idx_r;

    always_comb
    begin
      wr_idx_nxt = wr_idx_r;
      cwr_idx_nxt = cwr_idx_r;
      rd_idx_nxt = load_out ? wrap_inc(rd_idx_r) : rd_idx_r;
      com_nxt = com_r - sfifo_pkg::CNT_W'(load_out);
      unc_nxt = unc_r;
      bad_nxt = bad_r;
      if (keep)
      begin
        wr_idx_nxt = wrap_inc(wr_idx_r);
        if (!sf_mode)
        begin
          com_nxt = com_nxt + unc_r + sfifo_pkg::CNT_W'(1); // [R06]
          unc_nxt = '0;
          cwr_idx_nxt = wr_idx_nxt;
          bad_nxt = 1'b0;
        end
        else if (!eop_in)
        begin
          unc_nxt = unc_r + sfifo_pkg::CNT_W'(1);
          bad_nxt = bad_r || err_in;
        end
        else if (drop_r && USE_PACKETS && (bad_r || err_in))
        begin
          wr_idx_nxt = cwr_idx_r; // [R08]
          unc_nxt = '0;
          bad_nxt = 1'b0;
        end
        else
        begin
          com_nxt = com_nxt + unc_r + sfifo_pkg::CNT_W'(1); // [R07]
          unc_nxt = '0;
          cwr_idx_nxt = wr_idx_nxt;
          bad_nxt = 1'b0;
        end
      end
      else if (!sf_mode && unc_r != '0)
      begin
        // leaving store-and-forward releases any partial packet
        com_nxt = com_nxt + unc_r;
        unc_nxt = '0;
        cwr_idx_nxt = wr_idx_r;
        bad_nxt = 1'b0;
      end
    end

    always_ff @(posedge clk_sys)
    begin
      if (srst)
      begin
        wr_idx_r <= '0;
        cwr_idx_r <= '0;
        rd_idx_r <= '0;
        com_r <= '0;
        unc_r <= '0;
        bad_r <= 1'b0;
      end
      else
      begin
        wr_idx_r <= wr_idx_nxt;
        cwr_idx_r <= cwr_idx_nxt;
        rd_idx_r <= rd_idx_nxt;
        com_r <= com_nxt;
        unc_r <= unc_nxt;
        bad_r <= bad_nxt;
      end
    end
  end

  always_comb
  begin
    out_ent_nxt = out_ent_r;
    out_valid_nxt = out_valid_r && !out_ready;
    fwd_nxt = fwd_r;
    if (load_out)
    begin
      out_ent_nxt = mem[rd_idx];
      out_valid_nxt = 1'b1; // [R06]
      fwd_nxt = mem[rd_idx][E_EOP] ? sfifo_pkg::SFIFO_FWD_IDLE
                : sfifo_pkg::SFIFO_FWD_PKT; // [R12]
    end
  end

  // register port: first edge of a request latches read data, second completes
  always_comb
  begin
    sfifo_pkg::sfifo_mm_req_t rq;
    logic [2:0] idx;
    logic [1:0] en;
    rq = csr_in_req;
    idx = '0;
    en[0] = DUAL_CLOCK ? USE_SINK_FILL : USE_FILL_LEVEL; // [R04] [R05]
    en[1] = DUAL_CLOCK && USE_SOURCE_FILL; // [R05]
    af_thr_nxt = af_thr_r;
    ae_thr_nxt = ae_thr_r;
    cut_thr_nxt = cut_thr_r;
    drop_nxt = drop_r;
    for (int p = 0; p < 2; p++)
    begin
      rq = (p == 0) ? csr_in_req : csr_out_req;
      idx = rq.address[sfifo_pkg::ADDR_LSB +: 3];
      ack_nxt[p] = en[p] && (rq.read || rq.write) && !ack_r[p];
      rdata_nxt[p] = rdata_r[p];
      if (ack_nxt[p])
      begin
        rdata_nxt[p] = '0;
        if (32'(idx) == sfifo_pkg::REG_IDX_FILL)
        begin
          rdata_nxt[p] = sfifo_pkg::REG_W'((p == 0) ? fill_in : fill_out); // [R04] [R14]
        end
        else if (DUAL_CLOCK && 32'(idx) == sfifo_pkg::DC_IDX_THRESH)
        begin
          rdata_nxt[p] = sfifo_pkg::REG_W'((p == 0) ? af_thr_r : ae_thr_r);
        end
        else if (!DUAL_CLOCK && 32'(idx) == sfifo_pkg::REG_IDX_ALMOST_FULL)
        begin
          rdata_nxt[p] = sfifo_pkg::REG_W'(af_thr_r);
        end
        else if (!DUAL_CLOCK && 32'(idx) == sfifo_pkg::REG_IDX_ALMOST_EMPTY)
        begin
          rdata_nxt[p] = sfifo_pkg::REG_W'(ae_thr_r);
        end
        else if (!DUAL_CLOCK && 32'(idx) == sfifo_pkg::REG_IDX_CUT_THRESH)
        begin
          rdata_nxt[p] = sfifo_pkg::REG_W'(cut_thr_r);
        end
        else if (!DUAL_CLOCK && 32'(idx) == sfifo_pkg::REG_IDX_DROP_ERR)
        begin
          rdata_nxt[p] = sfifo_pkg::REG_W'(drop_r);
        end
      end
      if (ack_r[p] && rq.write)
      begin
        if (DUAL_CLOCK && 32'(idx) == sfifo_pkg::DC_IDX_THRESH)
        begin
          if (p == 0)
          begin
            af_thr_nxt = rq.writedata[sfifo_pkg::LVL_W-1:0];
          end
          else
          begin
            ae_thr_nxt = rq.writedata[sfifo_pkg::LVL_W-1:0];
          end
        end
        else if (!DUAL_CLOCK && 32'(idx) == sfifo_pkg::REG_IDX_ALMOST_FULL)
        begin
          af_thr_nxt = rq.writedata[sfifo_pkg::LVL_W-1:0];
        end
        else if (!DUAL_CLOCK && 32'(idx) == sfifo_pkg::REG_IDX_ALMOST_EMPTY)
        begin
          ae_thr_nxt = rq.writedata[sfifo_pkg::LVL_W-1:0];
        end
        else if (SF_BUILD && 32'(idx) == sfifo_pkg::REG_IDX_CUT_THRESH)
        begin
          cut_thr_nxt = rq.writedata[sfifo_pkg::LVL_W-1:0]; // [R09]
        end
        else if (SF_BUILD && USE_PACKETS && 32'(idx) == sfifo_pkg::REG_IDX_DROP_ERR)
        begin
          drop_nxt = rq.writedata[0]; // [R08]
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      out_ent_r <= '0;
      out_valid_r <= 1'b0;
      fwd_r <= sfifo_pkg::SFIFO_FWD_IDLE;
      af_thr_r <= ALMOST_FULL_RST;
      ae_thr_r <= sfifo_pkg::ALMOST_EMPTY_RST;
      cut_thr_r <= sfifo_pkg::CUT_THRESH_RST;
      drop_r <= sfifo_pkg::DROP_ERR_RST;
      almost_full_r <= 1'b0;
      almost_empty_r <= 1'b0;
      ack_r <= '0;
      rdata_r[0] <= '0;
      rdata_r[1] <= '0;
    end
    else
    begin
      out_ent_r <= out_ent_nxt;
      out_valid_r <= out_valid_nxt;
      fwd_r <= fwd_nxt;
      af_thr_r <= af_thr_nxt;
      ae_thr_r <= ae_thr_nxt;
      cut_thr_r <= cut_thr_nxt;
      drop_r <= drop_nxt;
      almost_full_r <= !DUAL_CLOCK && USE_ALMOST_FULL
                       && (sfifo_pkg::LVL_W'(fill_in) >= af_thr_r); // [R15] [R17]
      almost_empty_r <= !DUAL_CLOCK && USE_ALMOST_EMPTY
                        && (sfifo_pkg::LVL_W'(fill_in) <= ae_thr_r); // [R16] [R17]
      ack_r <= ack_nxt;
      rdata_r[0] <= rdata_nxt[0];
      rdata_r[1] <= rdata_nxt[1];
    end
  end

  assign out_valid = out_valid_r;
  assign out_data = out_ent_r[DW-1:0];
  assign out_eop = USE_PACKETS && out_ent_r[E_EOP]; // [R22]
  assign out_sop = out_ent_r[E_SOP];
  assign out_error = out_ent_r[E_ERR +: EW];
  assign out_channel = out_ent_r[E_CH +: CHANNEL_W]; // [R03]
  assign almost_full = almost_full_r;
  assign almost_empty = almost_empty_r;
  assign csr_in_waitrequest = (csr_in_req.read || csr_in_req.write) && !ack_r[0]
                              && (DUAL_CLOCK ? USE_SINK_FILL : USE_FILL_LEVEL);
  assign csr_out_waitrequest = (csr_out_req.read || csr_out_req.write) && !ack_r[1]
                               && DUAL_CLOCK && USE_SOURCE_FILL;
  assign csr_in_readdata = rdata_r[0];
  assign csr_out_readdata = rdata_r[1];
endmodule

// ---- rtl/sfifo_pkg.sv ----
// Overview of operation
// [R01] one stream sink and one stream source; dual form splits input and output clocks (here both sides run on clk_sys)
// [R02] ready latency zero: a beat moves when valid and ready are both high
// [R03] optional channel field, up to 255 channels, optional maximum channel 1 to 255
// [R04] 32-bit registers: fill level, limits; single form adds packet and error control
// [R05] dual form has one register port per side, each with its own build option
// [R06] default mode forwards accepted beats in order; valid while any beat is available
// [R07] store-and-forward shows valid only after a whole packet up to eop is stored
// [R08] store-and-forward with drop enabled discards every packet that carried an error
// [R09] cut-through threshold zero selects store-and-forward, above zero cut-through
// [R10] cut-through shows valid once stored entries reach the threshold
// [R11] a threshold of one behaves exactly as default mode
// [R12] cut-through keeps sending a started packet to eop; threshold needs store option
// [R13] dual form: input count never below truth, output count never above
// [R14] output stage counted on the output side only; free space is depth minus input count
// [R15] almost-full high while fill level is at or above its limit
// [R16] almost-empty high while fill level is at or below its limit
// [R17] the two status outputs are optional and exist only in the single-clock form
// [R18] data width is bits per symbol times symbols per beat, each 1 to 32
// [R19] depth 1 to 32; the output stage adds one entry of storage
// [R20] error sideband width 0 to 32, where 0 removes it
// [R21] dual form pointer synchronisers are 2 to 8 stages each
// [R22] option adds sop and eop markers to both ports
// [R23] dual form passes pointers between sides in gray code
package sfifo_pkg;
  localparam int unsigned REG_IDX_FILL = 0;
  localparam int unsigned REG_IDX_ALMOST_FULL = 2;
  localparam int unsigned REG_IDX_ALMOST_EMPTY = 3;
  localparam int unsigned REG_IDX_CUT_THRESH = 4;
  localparam int unsigned REG_IDX_DROP_ERR = 5;
  localparam int unsigned DC_IDX_FILL = 0;
  localparam int unsigned DC_IDX_THRESH = 1;
  localparam int unsigned BYTES_PER_REG = 4;
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned MM_ADDR_W = 5;
  localparam int unsigned REG_W = 32;
  localparam int unsigned LVL_W = 24;
  localparam int unsigned CNT_W = 7;
  localparam logic [23:0] ALMOST_EMPTY_RST = 24'h000000;
  localparam logic [23:0] CUT_THRESH_RST = 24'h000000;
  localparam logic DROP_ERR_RST = 1'b0;
  localparam int unsigned MAX_DEPTH = 32;
  localparam int unsigned MAX_SYNC = 8;
  localparam int unsigned MIN_SYNC = 2;

  typedef struct packed {
    logic read;
    logic write;
    logic [MM_ADDR_W-1:0] address;
    logic [REG_W-1:0] writedata;
  } sfifo_mm_req_t;

  typedef enum logic
  {
    SFIFO_FWD_IDLE = 1'b0,
    SFIFO_FWD_PKT = 1'b1
  } sfifo_fwd_t;
endpackage

// ---- bench/sfifo_chk_sva.sv ----
`timescale 1ns/1ns
module sfifo_chk_sva
#(
  parameter int BITS_PER_SYMBOL = 8,
  parameter int SYMBOLS_PER_BEAT = 1
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [BITS_PER_SYMBOL*SYMBOLS_PER_BEAT-1:0] out_data,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_sop,
  input wire logic out_eop,
  input wire sfifo_pkg::sfifo_mm_req_t csr_in_req,
  input wire logic [sfifo_pkg::REG_W-1:0] csr_in_readdata,
  input wire logic csr_in_waitrequest
);
  logic mid_r;
  logic mid_nxt;
  // tracks whether the source is inside a packet
  always_comb
  begin
    mid_nxt = mid_r;
    if (out_valid && out_ready)
      mid_nxt = !out_eop;
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      mid_r <= 1'b0;
    else
      mid_r <= mid_nxt;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  valid_hold_a: assert property (out_valid && !out_ready |=> out_valid)
    else $error("source valid dropped before it was taken");
  data_hold_a: assert property (out_valid && !out_ready
    |=> $stable({out_data, out_sop, out_eop}))
    else $error("source beat changed while stalled");
  rd_wait_a: assert property ($rose(csr_in_req.read)
    |-> csr_in_waitrequest ##1 !csr_in_waitrequest)
    else $error("register read not answered in two edges");
  wr_wait_a: assert property ($rose(csr_in_req.write)
    |-> csr_in_waitrequest ##1 !csr_in_waitrequest)
    else $error("register write not answered in two edges");
  wait_cause_a: assert property (csr_in_waitrequest
    |-> csr_in_req.read || csr_in_req.write)
    else $error("waitrequest high with no request");
  rdata_hold_a: assert property (!(csr_in_req.read || csr_in_req.write)
    |=> $stable(csr_in_readdata))
    else $error("read data changed without an access");
  sop_first_a: assert property (out_valid && !mid_r |-> out_sop)
    else $error("packet started without sop");
  sop_inside_a: assert property (out_valid && mid_r |-> !out_sop)
    else $error("sop inside a packet");
endmodule
bind sfifo_top sfifo_chk_sva
#(.BITS_PER_SYMBOL(BITS_PER_SYMBOL), .SYMBOLS_PER_BEAT(SYMBOLS_PER_BEAT)) i_chk
(
  .clk_sys(clk_sys),
  .srst(srst),
  .out_data(out_data),
  .out_valid(out_valid),
  .out_ready(out_ready),
  .out_sop(out_sop),
  .out_eop(out_eop),
  .csr_in_req(csr_in_req),
  .csr_in_readdata(csr_in_readdata),
  .csr_in_waitrequest(csr_in_waitrequest)
);

// ---- bench/sfifo_sink_model.sv ----
`timescale 1ns/1ns
module sfifo_sink_model
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [1:0] mode,
  input wire logic out_valid,
  input wire logic [10:0] beat,
  output logic out_ready = 1'b0
);
  integer seed = 46040;
  logic [10:0] got[$];
  // mode 0 prompt, 1 random stalls, 2 held off so the buffer fills
  always @(posedge clk_sys)
  begin
    if (!srst && out_valid && out_ready)
      got.push_back(beat);
    out_ready <= (mode == 2'h0) || ((mode == 2'h1) && ($random(seed) % 2 != 0));
  end
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ns
module tb;
  localparam int DEPTH = 4;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] in_data = 8'h00;
  logic in_valid = 1'b0;
  logic in_sop = 1'b0;
  logic in_eop = 1'b0;
  logic [0:0] in_error = 1'b0;
  logic in_ready, out_valid, out_ready, out_sop, out_eop, almost_full, almost_empty;
  logic csr_in_waitrequest;
  logic [7:0] out_data;
  logic [0:0] out_error;
  logic [31:0] csr_in_readdata;
  logic [31:0] rd;
  logic [1:0] mode = 2'h0;
  sfifo_pkg::sfifo_mm_req_t csr_req = '0;
  integer seed = 46040;
  int num_errors = 0;
  int check_count = 0;
  logic [10:0] exp_q[$];
  always #5 clk_sys = ~clk_sys;
  sfifo_top #(.ERROR_W(1), .DEPTH(DEPTH), .USE_STORE_FWD(1'b1)) i_sfifo_top
  (
    .clk_sys(clk_sys), .srst(srst), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready), .in_sop(in_sop), .in_eop(in_eop), .in_error(in_error),
    .in_channel(1'b0), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_sop(out_sop), .out_eop(out_eop), .out_error(out_error), .out_channel(),
    .almost_full(almost_full), .almost_empty(almost_empty), .csr_in_req(csr_req),
    .csr_in_readdata(csr_in_readdata), .csr_in_waitrequest(csr_in_waitrequest),
    .csr_out_req('0), .csr_out_readdata(), .csr_out_waitrequest()
  );
  sfifo_sink_model u_sink
  (
    .clk_sys(clk_sys), .srst(srst), .mode(mode), .out_valid(out_valid),
    .beat({out_sop, out_eop, out_error, out_data}), .out_ready(out_ready)
  );
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want)
    begin
      num_errors++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic bound(input logic hit);
    if (hit)
    begin
      num_errors++;
      print_verdict();
    end
  endtask
  // request held until the edge where waitrequest is low
  task automatic csr(input logic wr, input logic [4:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk_sys);
    csr_req <= '{read: !wr, write: wr, address: idx << 2, writedata: wd};
    // waitrequest and read data are taken at the completing rising edge
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (csr_in_waitrequest !== 1'b0 && n < 200);
    bound(n >= 200);
    rd = csr_in_readdata;
    csr_req <= '0;
  endtask
  task automatic beat(input logic s, input logic e, input logic er, input logic keep);
    logic [7:0] d;
    int n;
    d = 8'($random(seed));
    n = 0;
    @(posedge clk_sys);
    in_valid <= 1'b1;
    in_sop <= s;
    in_eop <= e;
    in_error <= er;
    in_data <= d;
    if (keep)
      exp_q.push_back({s, e, er, d});
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (in_ready !== 1'b1 && n < 200);
    bound(n >= 200);
  endtask
  task automatic idle();
    @(posedge clk_sys);
    in_valid <= 1'b0;
  endtask
  task automatic pkt(input int len, input int bad);
    for (int i = 0; i < len; i++)
      beat(i == 0, i == len - 1, i == bad, bad < 0);
    idle();
  endtask
  task automatic watch(input int n, output int v);
    v = 0;
    repeat (n)
    begin
      @(negedge clk_sys);
      if (out_valid === 1'b1)
        v++;
    end
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (u_sink.got.size() != exp_q.size() && n < 500)
    begin
      @(negedge clk_sys);
      n++;
    end
    bound(n >= 500);
  endtask
  initial
  begin
    int v;
    int len;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      csr(1'b0, 5'(i), 32'h0);
      check(rd, (i == 2) ? DEPTH - 1 : 0);
      csr(1'b1, 5'(i), 32'h3);
      csr(1'b0, 5'(i), 32'h0);
      check(rd, (i >= 2 && i <= 4) ? 3 : (i == 5) ? 1 : 0);
    end
    csr(1'b1, 5'h04, 32'h0);
    beat(1'b1, 1'b0, 1'b0, 1'b1);
    beat(1'b0, 1'b0, 1'b0, 1'b1);
    idle();
    watch(8, v);
    check(v, 0);
    // closing beat of the same packet: a fresh sop here would break framing
    beat(1'b0, 1'b1, 1'b0, 1'b1);
    idle();
    watch(8, v);
    check(32'(v > 0), 1);
    mode <= 2'h1;
    pkt(DEPTH, DEPTH - 1);
    // random lengths stay within depth: longer packets would never complete
    for (int k = 0; k < 16; k++)
    begin
      len = 1 + int'($unsigned($random(seed)) % DEPTH);
      pkt(len, int'($unsigned($random(seed)) % (2 * len)) - len);
    end
    drain();
    mode <= 2'h0;
    csr(1'b1, 5'h04, 32'h3);
    beat(1'b1, 1'b0, 1'b0, 1'b1);
    beat(1'b0, 1'b0, 1'b0, 1'b1);
    idle();
    watch(8, v);
    check(v, 0);
    beat(1'b0, 1'b0, 1'b0, 1'b1);
    idle();
    watch(8, v);
    check(32'(v > 0), 1);
    beat(1'b0, 1'b0, 1'b0, 1'b1);
    beat(1'b0, 1'b1, 1'b0, 1'b1);
    idle();
    drain();
    check(32'(u_sink.got[$]), 32'(exp_q[$]));
    csr(1'b1, 5'h04, 32'h1);
    beat(1'b1, 1'b0, 1'b0, 1'b1);
    idle();
    watch(8, v);
    check(32'(v > 0), 1);
    beat(1'b0, 1'b1, 1'b0, 1'b1);
    idle();
    drain();
    mode <= 2'h2;
    csr(1'b1, 5'h03, 32'h1);
    beat(1'b1, 1'b0, 1'b0, 1'b1);
    idle();
    watch(4, v);
    check(almost_empty, 1'b1);
    beat(1'b0, 1'b0, 1'b0, 1'b1);
    beat(1'b0, 1'b0, 1'b0, 1'b1);
    idle();
    watch(4, v);
    check(almost_full, 1'b1);
    check(almost_empty, 1'b0);
    beat(1'b0, 1'b0, 1'b0, 1'b1);
    beat(1'b0, 1'b1, 1'b0, 1'b1);
    idle();
    @(negedge clk_sys);
    check(in_ready, 1'b0);
    csr(1'b0, 5'h00, 32'h0);
    check(rd, DEPTH + 1);
    mode <= 2'h0;
    drain();
    watch(4, v);
    check(almost_empty, 1'b1);
    check(almost_full, 1'b0);
    for (int i = 0; i < exp_q.size(); i++)
      check(32'(u_sink.got[i]), 32'(exp_q[i]));
    print_verdict();
  end
endmodule
